// File: design/nba_defines.svh
// constants for the notch boxcar averager
`ifndef NBA_DEFINES_SVH
`define NBA_DEFINES_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define NBA_CLK_PERIOD_NS   10
`define NBA_CYC_PER_US      (1000 / `NBA_CLK_PERIOD_NS)
`define NBA_OVERHEAD_NS     500
`define NBA_OVERHEAD_CYC    ((`NBA_OVERHEAD_NS + `NBA_CLK_PERIOD_NS - 1) / `NBA_CLK_PERIOD_NS)
`define NBA_DEFAULT_SETTLE_US 450

// ----------------------------------------------------------------
// converter and sequence
// ----------------------------------------------------------------
`define NBA_SAMPLE_RATE_HZ  31250
`define NBA_BRIDGE_PHASES   4
`define NBA_SINGLE_PHASES   1

`endif

// File: design/nba_pkg.sv
// types for the notch boxcar averager
package nba_pkg;
    typedef enum logic [2:0] {
        S_IDLE,
        S_CALC,
        S_SETTLE,
        S_AVERAGE,
        S_DIVIDE,
        S_OVERHEAD
    } state_t;
endpackage

// File: design/notch_boxcar_averager.sv
// boxcar averaging filter with programmable first notch
// Operation
// - converter samples arrive at 31250 per second and that rate is the base of every averaging count.
// - each result is the mean of one block of consecutive samples per phase, each block as long as the rate over the notch frequency.
// - the averaging count is rounded to a whole number of samples, so the real notch may shift slightly.
// - the first notch frequency is programmable and nulls itself and all its integer multiples.
// - the filtering phase lasts one period of the notch frequency.
// - a settling setting of zero picks the built-in default, any other value is used as given.
// - a result is made of settling, then averaging, then fixed overhead.
// - a bridge measurement with both reversals settles again in each of four phases.
`timescale 1ns/1ps
`include "nba_defines.svh"

module notch_boxcar_averager #(
    parameter int SW    = 24,
    parameter int ACC_W = SW + 17
) (
    // clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    input  wire logic                 clk_en,
    // converter sample stream
    input  wire logic                 sample_valid,
    input  wire logic signed [SW-1:0] sample_data,
    // measurement sequencer
    input  wire logic                 start,
    input  wire logic                 bridge_mode,
    input  wire logic [15:0]          first_notch_freq,
    input  wire logic [15:0]          settle_interval_setting,
    output logic                      busy,
    output logic signed [SW-1:0]      result,
    output logic                      result_valid,
    output logic [15:0]               avg_count
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    localparam logic [6:0]  CYC_US  = 7'(`NBA_CYC_PER_US);
    localparam logic [15:0] OVH_CYC = 16'(`NBA_OVERHEAD_CYC);
    localparam logic [6:0]  DIV_N   = 7'(ACC_W);

    function automatic logic [15:0] settle_load(input logic [15:0] cfg);
        return (cfg == 16'h0000) ? 16'(`NBA_DEFAULT_SETTLE_US) : cfg;
    endfunction

    // one restoring step: returns {remainder, quotient}
    function automatic logic [2*ACC_W-1:0] div_step(input logic [ACC_W-1:0] rem,
                                                    input logic [ACC_W-1:0] quo,
                                                    input logic [ACC_W-1:0] dvs);
        logic [ACC_W-1:0] r;
        logic [ACC_W-1:0] q;
        r = {rem[ACC_W-2:0], quo[ACC_W-1]};
        q = {quo[ACC_W-2:0], 1'b0};
        if (r >= dvs) begin
            r    = r - dvs;
            q[0] = 1'b1;
        end
        return {r, q};
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    nba_pkg::state_t          state, next_state;
    logic [15:0]              freq, next_freq;
    logic [15:0]              settle_cfg, next_settle_cfg;
    logic                     bridge, next_bridge;
    logic [15:0]              settle_us, next_settle_us;
    logic [6:0]               pre, next_pre;
    logic [2:0]               phase, next_phase;
    logic [15:0]              smp_cnt, next_smp_cnt;
    logic signed [ACC_W-1:0]  acc, next_acc;
    logic signed [ACC_W-1:0]  tot, next_tot;
    logic [ACC_W-1:0]         rem, next_rem;
    logic [ACC_W-1:0]         quo, next_quo;
    logic [ACC_W-1:0]         dvs, next_dvs;
    logic [6:0]               dbits, next_dbits;
    logic                     neg, next_neg;
    logic [15:0]              ovh, next_ovh;
    logic                     next_busy;
    logic signed [SW-1:0]     next_result;
    logic                     next_result_valid;
    logic [15:0]              next_avg_count;
    logic [2:0]               last_phase;
    logic [2*ACC_W-1:0]       step;
    logic signed [ACC_W-1:0]  sum;

    assign last_phase = bridge ? 3'(`NBA_BRIDGE_PHASES - 1) : 3'(`NBA_SINGLE_PHASES - 1);

    always_comb begin
        next_state        = state;
        next_freq         = freq;
        next_settle_cfg   = settle_cfg;
        next_bridge       = bridge;
        next_settle_us    = settle_us;
        next_pre          = pre;
        next_phase        = phase;
        next_smp_cnt      = smp_cnt;
        next_acc          = acc;
        next_tot          = tot;
        next_rem          = rem;
        next_quo          = quo;
        next_dvs          = dvs;
        next_dbits        = dbits;
        next_neg          = neg;
        next_ovh          = ovh;
        next_busy         = busy;
        next_result       = result;
        next_result_valid = 1'b0;
        next_avg_count    = avg_count;
        step              = div_step(rem, quo, dvs);
        sum               = tot + acc;
        case (state)
            nba_pkg::S_IDLE: begin
                if (start) begin
                    // zero notch would divide by zero; treat as 1 Hz
                    next_freq       = (first_notch_freq == 16'h0000) ? 16'h0001 : first_notch_freq;
                    next_settle_cfg = settle_interval_setting;
                    next_bridge     = bridge_mode;
                    // round to nearest: (rate + f/2) / f
                    next_rem   = '0;
                    next_quo   = ACC_W'(`NBA_SAMPLE_RATE_HZ) + ACC_W'(first_notch_freq[15:1]);
                    next_dvs   = ACC_W'(next_freq);
                    next_dbits = DIV_N;
                    next_busy  = 1'b1;
                    next_state = nba_pkg::S_CALC;
                end
            end
            nba_pkg::S_CALC: begin
                next_rem   = step[2*ACC_W-1:ACC_W];
                next_quo   = step[ACC_W-1:0];
                next_dbits = dbits - 7'h01;
                if (dbits == 7'h01) begin
                    next_avg_count = step[15:0];
                    next_phase     = 3'h0;
                    next_tot       = '0;
                    next_settle_us = settle_load(settle_cfg);
                    next_pre       = 7'h00;
                    next_state     = nba_pkg::S_SETTLE;
                end
            end
            nba_pkg::S_SETTLE: begin
                if (settle_us == 16'h0000) begin
                    next_acc     = '0;
                    next_smp_cnt = 16'h0000;
                    next_state   = nba_pkg::S_AVERAGE;
                end else if (pre == CYC_US - 7'h01) begin
                    next_pre       = 7'h00;
                    next_settle_us = settle_us - 16'h0001;
                end else begin
                    next_pre = pre + 7'h01;
                end
            end
            nba_pkg::S_AVERAGE: begin
                // one notch period of samples: the boxcar nulls f and its multiples
                if (sample_valid) begin
                    next_acc     = acc + ACC_W'(sample_data);
                    next_smp_cnt = smp_cnt + 16'h0001;
                    if (smp_cnt == avg_count - 16'h0001) begin
                        next_tot = tot + acc + ACC_W'(sample_data);
                        if (phase == last_phase) begin
                            // divide magnitude so the mean truncates toward zero
                            next_neg   = (sum + ACC_W'(sample_data)) < 0;
                            next_rem   = '0;
                            next_quo   = ACC_W'(next_neg ? -(sum + ACC_W'(sample_data)) : sum + ACC_W'(sample_data));
                            next_dvs   = ACC_W'(avg_count) * ACC_W'(last_phase + 3'h1);
                            next_dbits = DIV_N;
                            next_state = nba_pkg::S_DIVIDE;
                        end else begin
                            // each reversal phase settles afresh
                            next_phase     = phase + 3'h1;
                            next_settle_us = settle_load(settle_cfg);
                            next_pre       = 7'h00;
                            next_state     = nba_pkg::S_SETTLE;
                        end
                    end
                end
            end
            nba_pkg::S_DIVIDE: begin
                next_rem   = step[2*ACC_W-1:ACC_W];
                next_quo   = step[ACC_W-1:0];
                next_dbits = dbits - 7'h01;
                if (dbits == 7'h01) begin
                    next_result = neg ? -SW'(step[ACC_W-1:0]) : SW'(step[ACC_W-1:0]);
                    next_ovh    = 16'h0000;
                    next_state  = nba_pkg::S_OVERHEAD;
                end
            end
            nba_pkg::S_OVERHEAD: begin
                next_ovh = ovh + 16'h0001;
                if (ovh == OVH_CYC - 16'h0001) begin
                    next_result_valid = 1'b1;
                    next_busy         = 1'b0;
                    next_state        = nba_pkg::S_IDLE;
                end
            end
            default: begin
                next_state = nba_pkg::S_IDLE;
                next_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state        <= nba_pkg::S_IDLE;
            freq         <= 16'h0001;
            settle_cfg   <= 16'h0000;
            bridge       <= 1'b0;
            settle_us    <= 16'h0000;
            pre          <= 7'h00;
            phase        <= 3'h0;
            smp_cnt      <= 16'h0000;
            acc          <= '0;
            tot          <= '0;
            rem          <= '0;
            quo          <= '0;
            dvs          <= '0;
            dbits        <= 7'h00;
            neg          <= 1'b0;
            ovh          <= 16'h0000;
            busy         <= 1'b0;
            result       <= '0;
            result_valid <= 1'b0;
            avg_count    <= 16'h0000;
        end else if (clk_en) begin
            state        <= next_state;
            freq         <= next_freq;
            settle_cfg   <= next_settle_cfg;
            bridge       <= next_bridge;
            settle_us    <= next_settle_us;
            pre          <= next_pre;
            phase        <= next_phase;
            smp_cnt      <= next_smp_cnt;
            acc          <= next_acc;
            tot          <= next_tot;
            rem          <= next_rem;
            quo          <= next_quo;
            dvs          <= next_dvs;
            dbits        <= next_dbits;
            neg          <= next_neg;
            ovh          <= next_ovh;
            busy         <= next_busy;
            result       <= next_result;
            result_valid <= next_result_valid;
            avg_count    <= next_avg_count;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_last_sample;
        clk_en && state == nba_pkg::S_AVERAGE && sample_valid && smp_cnt == avg_count - 16'h0001;
    endsequence

    property p_strobe_one;
        clk_en && result_valid |=> !result_valid;
    endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("valid strobe longer than one cycle");
    property p_strobe_cause;
        $rose(result_valid) |-> $past(state) == nba_pkg::S_OVERHEAD && state == nba_pkg::S_IDLE;
    endproperty
    a_strobe_cause: assert property (p_strobe_cause) else $error("valid strobe not after overhead");
    property p_acc_clear;
        $rose(state == nba_pkg::S_AVERAGE) |-> acc == '0 && smp_cnt == 16'h0000;
    endproperty
    a_acc_clear: assert property (p_acc_clear) else $error("accumulator not clear at interval start");
    property p_settle_load;
        $rose(state == nba_pkg::S_SETTLE) |->
            settle_us == ((settle_cfg == 16'h0000) ? 16'(`NBA_DEFAULT_SETTLE_US) : settle_cfg);
    endproperty
    a_settle_load: assert property (p_settle_load) else $error("settling interval wrongly loaded");
    property p_round;
        state == nba_pkg::S_SETTLE |->
            32'(avg_count) * 32'(freq) <= 32'(`NBA_SAMPLE_RATE_HZ) + 32'(freq[15:1]) &&
            32'(avg_count) * 32'(freq) + 32'(freq) > 32'(`NBA_SAMPLE_RATE_HZ) + 32'(freq[15:1]);
    endproperty
    a_round: assert property (p_round) else $error("averaging count not rounded rate over notch");
    property p_avg_len;
        s_last_sample |=> state != nba_pkg::S_AVERAGE;
    endproperty
    a_avg_len: assert property (p_avg_len) else $error("averaging did not end after count samples");
    property p_phases;
        $rose(state == nba_pkg::S_DIVIDE) |->
            phase == (bridge ? 3'(`NBA_BRIDGE_PHASES - 1) : 3'(`NBA_SINGLE_PHASES - 1));
    endproperty
    a_phases: assert property (p_phases) else $error("wrong number of settle phases");
    property p_overhead;
        state == nba_pkg::S_OVERHEAD |-> ovh < OVH_CYC;
    endproperty
    a_overhead: assert property (p_overhead) else $error("overhead overran its count");

endmodule

// File: tb/adc_stream_model.sv
// converter model: fixed-rate sample stream alternating two levels
`timescale 1ns/1ps

module adc_stream_model #(
    parameter int PER = 4
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // levels to send, alternating
    input  wire logic signed [23:0] level_a,
    input  wire logic signed [23:0] level_b,
    // sample stream
    output logic                    sample_valid,
    output logic signed [23:0]      sample_data
);
    int   cnt;
    logic ph;

    // ----------------------------------------
    // stream
    // ----------------------------------------
    // stream runs much faster than the real rate so the run stays short
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt          <= 0;
            ph           <= 1'b0;
            sample_valid <= 1'b0;
            sample_data  <= 24'h00_0000;
        end else if (cnt == PER - 1) begin
            cnt          <= 0;
            ph           <= ~ph;
            sample_valid <= 1'b1;
            sample_data  <= ph ? level_b : level_a;
        end else begin
            cnt          <= cnt + 1;
            sample_valid <= 1'b0;
            // no valid sample: data wanders so a stray capture shows up
            sample_data  <= ~sample_data;
        end
    end
endmodule

// File: tb/tb_notch_boxcar_averager.sv
// self-checking bench for the boxcar averager
`timescale 1ns/1ps
`include "nba_defines.svh"

`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end

module tb_notch_boxcar_averager;
    localparam int PER = 4;
    localparam int SR  = `NBA_SAMPLE_RATE_HZ;

    logic               clk_sys  = 1'b0;
    logic               rst_b    = 1'b0;
    logic               clk_en   = 1'b1;
    logic               start    = 1'b0;
    logic               bridge_mode = 1'b0;
    logic [15:0]        fnf      = 16'h0000;
    logic [15:0]        settle   = 16'h0000;
    logic signed [23:0] lvl_a    = 24'h00_0000;
    logic signed [23:0] lvl_b    = 24'h00_0000;
    wire                sample_valid;
    wire signed [23:0]  sample_data;
    logic               busy;
    logic signed [23:0] result;
    logic               result_valid;
    logic [15:0]        avg_count;
    int                 err_count = 0;
    int                 cmp_count = 0;
    int                 cyc       = 0;

    always #5 clk_sys = ~clk_sys;

    adc_stream_model #(.PER(PER)) adc (
        .clk_sys(clk_sys), .rst_b(rst_b), .level_a(lvl_a), .level_b(lvl_b),
        .sample_valid(sample_valid), .sample_data(sample_data));

    notch_boxcar_averager dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
        .sample_valid(sample_valid), .sample_data(sample_data),
        .start(start), .bridge_mode(bridge_mode), .first_notch_freq(fnf),
        .settle_interval_setting(settle), .busy(busy), .result(result),
        .result_valid(result_valid), .avg_count(avg_count));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one measurement, judged on count, mean and strobe; returns latency
    task automatic measure(input logic [15:0] f, input logic [15:0] s, input logic br,
                           input int a, input int b, output int lat);
        int                 n;
        logic signed [23:0] e;
        n = (SR + f / 2) / f;
        e = 24'((a + b) / 2);
        lvl_a = 24'(a);
        lvl_b = 24'(b);
        fnf = f;
        settle = s;
        bridge_mode = br;
        start = 1'b1;
        @(posedge clk_sys) #1;
        start = 1'b0;
        `CHK("busy_up", 1'b1, busy)
        lat = 1;
        while (result_valid !== 1'b1 && lat < 60000) begin
            @(posedge clk_sys) #1;
            lat++;
        end
        `CHK("strobe_up", 1'b1, result_valid)
        `CHK("avg_count", n[15:0], avg_count)
        `CHK("result", e, result)
        `CHK("busy_down", 1'b0, busy)
        @(posedge clk_sys) #1;
        `CHK("strobe", 1'b0, result_valid)
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // five notches from fastest to mains, incl. full scale and truncation
    task automatic t_notches();
        logic [15:0] ft [5] = '{16'h7A12, 16'h3D09, 16'h186A, 16'h003C, 16'h0032};
        int          at [5] = '{-7, -3, 123, 8388607, -8388608};
        int          bt [5] = '{-7, -2, 123, 8388607, -8388608};
        int          lat [5];
        for (int i = 0; i < 5; i++)
            measure(ft[i], 16'h0001, 1'b0, at[i], bt[i], lat[i]);
        `CHK("filter_span", 1'b1, (lat[4] - lat[2]) inside {[620 * PER - PER - 2 : 620 * PER + PER + 2]})
    endtask

    task automatic t_settle();
        int l0;
        int l1;
        int l3;
        measure(16'h7A12, 16'h0001, 1'b0, 42, 42, l1);
        measure(16'h7A12, 16'h0003, 1'b0, 42, 42, l3);
        `CHK("settle_set", 1'b1, (l3 - l1) inside {[200 - PER - 2 : 200 + PER + 2]})
        measure(16'h7A12, 16'h0000, 1'b0, 42, 42, l0);
        `CHK("settle_def", 1'b1, (l0 - l1) inside {[44900 - PER - 2 : 44900 + PER + 2]})
    endtask

    task automatic t_bridge();
        int l1;
        int l3;
        measure(16'h3D09, 16'h0001, 1'b1, 5, 6, l1);
        measure(16'h3D09, 16'h0003, 1'b1, 5, 6, l3);
        `CHK("bridge_settle", 1'b1, (l3 - l1) inside {[800 - 4 * PER - 2 : 800 + 4 * PER + 2]})
    endtask

    // clock enable low mid-measurement stretches it by the frozen cycles only
    task automatic t_freeze();
        int l1;
        int l2;
        measure(16'h7A12, 16'h0001, 1'b0, 42, 42, l1);
        fork
            measure(16'h7A12, 16'h0001, 1'b0, 42, 42, l2);
            begin
                repeat (20) @(posedge clk_sys);
                #1;
                clk_en = 1'b0;
                repeat (100) @(posedge clk_sys);
                #1;
                `CHK("frz_busy", 1'b1, busy)
                clk_en = 1'b1;
            end
        join
        `CHK("frz_span", 1'b1, (l2 - l1) inside {[100 - PER - 2 : 100 + PER + 2]})
    endtask

    // reset in mid-measurement returns every output to idle, then a fresh run works
    task automatic t_reset();
        int l;
        fnf = 16'h3D09;
        settle = 16'h0001;
        bridge_mode = 1'b0;
        start = 1'b1;
        @(posedge clk_sys) #1;
        start = 1'b0;
        repeat (150) @(posedge clk_sys);
        #1;
        `CHK("mid_busy", 1'b1, busy)
        rst_b = 1'b0;
        @(posedge clk_sys) #1;
        `CHK("rstm_busy", 1'b0, busy)
        `CHK("rstm_count", 16'h0000, avg_count)
        `CHK("rstm_result", 24'h00_0000, result)
        `CHK("rstm_strobe", 1'b0, result_valid)
        rst_b = 1'b1;
        measure(16'h3D09, 16'h0001, 1'b0, 9, 9, l);
    endtask

    // ----------------------------------------
    // main sequence and hang guard
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 90000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        `CHK("rst_busy", 1'b0, busy)
        `CHK("rst_count", 16'h0000, avg_count)
        t_notches();
        t_settle();
        t_bridge();
        t_freeze();
        t_reset();
        final_report();
    end
endmodule
